/* verilog/dbsp_port.sv */
// Link-side logic of the burst memory port plus its write backlog FIFO.
// Assumes the host keeps address and command aligned to the address edge
// and drives the complement clock half a period from the true clock.
`timescale 1ns/100ps
`default_nettype none


// =====================================================
// Synchronous FIFO
module dbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Pointer and fill bookkeeping
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = push ? PW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? PW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (PW+1)'(cnt_r + push - pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    assign in_ready = (cnt_r != DEPTH[PW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
endmodule

// =====================================================
// Memory port top
module dbsp_port
    import dbsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic k_clk,
    input wire logic k_n_clk,
    input wire logic [DBSP_ADDR_W-1:0] mem_addr,
    input wire logic issue_select_n,
    input wire logic rw_select,
    input wire logic [DBSP_WORD_W-1:0] dq_in,
    output logic [DBSP_WORD_W-1:0] dq_out,
    output logic dq_oe,
    output logic read_valid_flag,
    output logic echo_timing_out,
    output logic echo_timing_out_n,
    output logic [DBSP_CNT_W-1:0] commit_count,
    output logic write_backlog_full,
    output logic write_lost
);
    localparam int BW = DBSP_BURST_LEN * DBSP_WORD_W;
    localparam int FW = DBSP_ADDR_W + BW;

    // =====================================================
    // Link reset: async assert, released on the true clock
    logic krst_s1_r, k_rst_n_r;
    always_ff @(posedge k_clk or negedge rstn) begin
        if (!rstn) begin
            krst_s1_r <= 1'b0;
            k_rst_n_r <= 1'b0;
        end else begin
            krst_s1_r <= 1'b1;
            k_rst_n_r <= krst_s1_r;
        end
    end

    // =====================================================
    // True clock domain state
    dbsp_phase_t phase_r, phase_nxt;
    logic cmd_edge_r, cmd_edge_nxt;
    logic [DBSP_ADDR_W-1:0] addr_r, addr_nxt, wr_addr_r, wr_addr_nxt;
    logic ld_n_r, ld_n_nxt, rw_r, rw_nxt;
    logic [DBSP_WORD_W-1:0] din_k_r, din_k_nxt;
    logic rd_p1_r, rd_p1_nxt, wr_p1_r, wr_p1_nxt;
    logic [BW-1:0] rdata_r, rdata_nxt;
    logic oe_r, oe_nxt;
    logic [DBSP_WORD_W-1:0] a_k_r, a_k_nxt, tgt1_r, tgt1_nxt;
    logic echo_k_r, echo_k_nxt;
    logic tgl_r, tgl_nxt, lost_r, lost_nxt, full_r, full_nxt;
    // Complement clock state
    logic [DBSP_WORD_W-1:0] din_kn_r, din_kn_nxt, b_kn_r, b_kn_nxt;
    logic echo_kn_r, echo_kn_nxt;

    logic [BW-1:0] mem_r [2**DBSP_ADDR_W];
    logic req_rd, req_wr;
    logic push_ready, pop_valid, pop_ready, commit;
    logic [FW-1:0] push_data, pop_data;

    // Backlog of captured bursts waiting for the array
    dbsp_fifo #(
        .WIDTH(FW),
        .DEPTH(DBSP_FIFO_DEPTH)
    ) u_backlog (
        .clk(k_clk),
        .rst_n(k_rst_n_r),
        .in_valid(wr_p1_r),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // Command decode, write assembly and read launch
    always_comb begin
        req_rd = cmd_edge_r && !ld_n_r && rw_r;
        req_wr = cmd_edge_r && !ld_n_r && !rw_r;
        phase_nxt = (phase_r == DBSP_PH_ADDR) ? DBSP_PH_DATA : DBSP_PH_ADDR;
        cmd_edge_nxt = (phase_r == DBSP_PH_ADDR);
        addr_nxt = mem_addr;
        ld_n_nxt = issue_select_n;
        rw_nxt = rw_select;
        din_k_nxt = dq_in;
        rd_p1_nxt = req_rd;
        wr_p1_nxt = req_wr;
        wr_addr_nxt = req_wr ? addr_r : wr_addr_r;
        // word0 low half, word1 high half of one entry
        rdata_nxt = req_rd ? mem_r[addr_r] : rdata_r;
        // beat0 on true edge, beat1 on complement edge
        push_data = {wr_addr_r, din_kn_r, din_k_r};
        // array free unless a read uses it
        pop_ready = !req_rd;
        commit = pop_valid && pop_ready;
        // second stage puts word0 on the bus
        oe_nxt = rd_p1_r;
        // xor pair keeps each beat in its own register
        a_k_nxt = (rd_p1_r ? rdata_r[DBSP_WORD_W-1:0] : DBSP_WORD_RST)
            ^ b_kn_r;
        tgt1_nxt = rd_p1_r ? rdata_r[BW-1:DBSP_WORD_W] : DBSP_WORD_RST;
        // echo high after true edge, low after complement
        echo_k_nxt = !echo_kn_r;
        tgl_nxt = tgl_r ^ commit;
        // Cannot happen at full burst rate; flagged in case of misuse
        lost_nxt = lost_r || (wr_p1_r && !push_ready);
        full_nxt = !push_ready;
    end

    always_ff @(posedge k_clk or negedge k_rst_n_r) begin
        if (!k_rst_n_r) begin
            phase_r <= DBSP_PH_ADDR;
            cmd_edge_r <= 1'b0;
            addr_r <= DBSP_ADDR_RST;
            wr_addr_r <= DBSP_ADDR_RST;
            ld_n_r <= 1'b1;
            rw_r <= 1'b0;
            din_k_r <= DBSP_WORD_RST;
            rd_p1_r <= 1'b0;
            wr_p1_r <= 1'b0;
            rdata_r <= '0;
            oe_r <= 1'b0;
            a_k_r <= DBSP_WORD_RST;
            tgt1_r <= DBSP_WORD_RST;
            echo_k_r <= 1'b0;
            tgl_r <= 1'b0;
            lost_r <= 1'b0;
            full_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cmd_edge_r <= cmd_edge_nxt;
            addr_r <= addr_nxt;
            wr_addr_r <= wr_addr_nxt;
            ld_n_r <= ld_n_nxt;
            rw_r <= rw_nxt;
            din_k_r <= din_k_nxt;
            rd_p1_r <= rd_p1_nxt;
            wr_p1_r <= wr_p1_nxt;
            rdata_r <= rdata_nxt;
            oe_r <= oe_nxt;
            a_k_r <= a_k_nxt;
            tgt1_r <= tgt1_nxt;
            echo_k_r <= echo_k_nxt;
            tgl_r <= tgl_nxt;
            lost_r <= lost_nxt;
            full_r <= full_nxt;
        end
    end

    // self-timed commit of a whole burst
    always_ff @(posedge k_clk) begin
        if (commit) begin
            mem_r[pop_data[FW-1:BW]] <= pop_data[BW-1:0];
        end
    end

    // =====================================================
    // Complement clock: second write beat, second read beat, echo
    // rising edge of the complement clock, never a falling edge
    always_comb begin
        din_kn_nxt = dq_in;
        b_kn_nxt = tgt1_r ^ a_k_r;
        echo_kn_nxt = echo_k_r;
    end

    always_ff @(posedge k_n_clk or negedge k_rst_n_r) begin
        if (!k_rst_n_r) begin
            din_kn_r <= DBSP_WORD_RST;
            b_kn_r <= DBSP_WORD_RST;
            echo_kn_r <= 1'b0;
        end else begin
            din_kn_r <= din_kn_nxt;
            b_kn_r <= b_kn_nxt;
            echo_kn_r <= echo_kn_nxt;
        end
    end

    // pins formed only from output registers
    assign dq_out = a_k_r ^ b_kn_r;
    // shared pins driven only for reads
    // released unless a read burst is returning
    assign dq_oe = oe_r;
    // valid tracks the driven read data
    assign read_valid_flag = oe_r;
    assign echo_timing_out = echo_k_r ^ echo_kn_r;
    assign echo_timing_out_n = !(echo_k_r ^ echo_kn_r);

    // =====================================================
    // Reference clock side: commit count and backlog status
    logic ts1_r, ts2_r, ts3_r, fs1_r, fs2_r, ls1_r, ls2_r;
    logic [DBSP_CNT_W-1:0] cnt_r, cnt_nxt;

    // Toggle crossing turns each commit into one count
    always_comb begin
        cnt_nxt = (ts2_r ^ ts3_r) ? DBSP_CNT_W'(cnt_r + 1'b1) : cnt_r;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ts1_r <= 1'b0;
            ts2_r <= 1'b0;
            ts3_r <= 1'b0;
            fs1_r <= 1'b0;
            fs2_r <= 1'b0;
            ls1_r <= 1'b0;
            ls2_r <= 1'b0;
            cnt_r <= DBSP_CNT_RST;
        end else begin
            ts1_r <= tgl_r;
            ts2_r <= ts1_r;
            ts3_r <= ts2_r;
            fs1_r <= full_r;
            fs2_r <= fs1_r;
            ls1_r <= lost_r;
            ls2_r <= ls1_r;
            cnt_r <= cnt_nxt;
        end
    end

    assign commit_count = cnt_r;
    assign write_backlog_full = fs2_r;
    assign write_lost = ls2_r;

    // =====================================================
    // Checks on the link side
    a_addr_alt_edge:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        cmd_edge_r |=> !cmd_edge_r)
    else $error("address taken on two adjacent edges");

    a_write_push:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        req_wr |=> wr_p1_r && push_data[FW-1:BW] == $past(addr_r))
    else $error("write burst not queued one cycle after capture");

    a_read_latency:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        req_rd |-> ##2 (dq_oe && dq_out == tgt1_r))
    else $error("read data not on bus two cycles after address");

    a_valid_tracks_oe:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        read_valid_flag == dq_oe && read_valid_flag == $past(req_rd, 2))
    else $error("read valid differs from bus drive");

    a_echo_phase:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        $past(k_rst_n_r) |-> !echo_timing_out && echo_timing_out_n)
    else $error("echo not low after complement edge");

    a_second_beat:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        dq_out == tgt1_r)
    else $error("second beat register does not drive the pins");

    a_commit_free:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        commit |-> !req_rd && !rd_p1_nxt)
    else $error("array committed during a read");

    a_commit_lands:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        commit |=> mem_r[$past(pop_data[FW-1:BW])]
            == $past(pop_data[BW-1:0]))
    else $error("committed burst not held in the array");

    a_release_idle:
    assert property (@(posedge k_clk) disable iff (!k_rst_n_r)
        !req_rd |-> ##2 !dq_oe)
    else $error("bus driven without a read");
endmodule
`default_nettype wire

/* verilog/dbsp_pkg.sv */
// Shared constants for the two-word burst static memory port.
// Assumes a link clock pair (true and complement) from the host controller.
`default_nettype none
package dbsp_pkg;
    // =====================================================
    // Geometry
    localparam int DBSP_ADDR_W = 8;       // burst address bits; 256 bursts held on chip
    localparam int DBSP_WORD_W = 18;      // one data beat
    localparam int DBSP_BURST_LEN = 2;    // words per address
    localparam int DBSP_FIFO_DEPTH = 4;   // pending write bursts
    localparam int DBSP_CNT_W = 16;       // commit counter width
    // =====================================================
    // Timing in link clock cycles
    localparam int DBSP_RD_LATENCY = 2;
    // =====================================================
    // Reset values
    localparam logic [DBSP_CNT_W-1:0] DBSP_CNT_RST = 16'h0000;
    localparam logic [DBSP_WORD_W-1:0] DBSP_WORD_RST = 18'h00000;
    localparam logic [DBSP_ADDR_W-1:0] DBSP_ADDR_RST = 8'h00;
    // Alternating edge roles of the true link clock
    typedef enum logic [1:0] {
        DBSP_PH_ADDR = 2'b01,
        DBSP_PH_DATA = 2'b10
    } dbsp_phase_t;
endpackage
`default_nettype wire

/* tb/dbsp_host_model.sv */
// Host controller model: link clock pair, commands and write beats.
// Assumes the bench queues commands with issue() and owns rstn.
`timescale 1ns/100ps
`default_nettype none
module dbsp_host_model
    import dbsp_pkg::*;
(
    input wire logic rstn,
    output logic k_clk,
    output logic k_n_clk,
    output logic [DBSP_ADDR_W-1:0] mem_addr,
    output logic issue_select_n,
    output logic rw_select,
    output logic [DBSP_WORD_W-1:0] dq_in,
    input wire logic [DBSP_WORD_W-1:0] dq_out,
    input wire logic dq_oe,
    output logic clash
);
    typedef struct packed {
        logic rd;
        logic [DBSP_ADDR_W-1:0] a;
        logic [2*DBSP_WORD_W-1:0] w;
    } dbsp_cmd_t;
    dbsp_cmd_t cq[$];
    dbsp_cmd_t wc;
    int kc = 0;
    int rd_edge[$];
    int last_rd = -8;
    int wr_edge = -8;
    logic drv = 1'b0;
    logic due = 1'b0;
    logic rel;
    logic [DBSP_WORD_W-1:0] hv = DBSP_WORD_RST;

    task automatic issue(input logic rd, input logic [DBSP_ADDR_W-1:0] a,
                         input logic [2*DBSP_WORD_W-1:0] w);
        cq.push_back({rd, a, w});
    endtask

    // =====================================================
    // Free running clock pair; the port's reset sync needs edges
    // slow link clock
    initial begin
        k_clk = 1'b0;
        #0.7;
        forever begin
            k_clk = ~k_clk;
            #7.5;
        end
    end
    assign k_n_clk = ~k_clk;

    assign dq_in = dq_oe ? dq_out : (drv ? hv : ~hv);
    assign clash = dq_oe & drv;

    // Beats then next command, 1 ns after every true clock edge
    always @(posedge k_clk) begin
        kc = rstn ? kc + 1 : 0;
        #1;
        rel = 1'b0;
        if (kc == wr_edge) begin
            drv = 1'b1;
            hv = wc.w[DBSP_WORD_W-1:0];
            due = 1'b1;
        end else if (due) begin
            hv = wc.w[2*DBSP_WORD_W-1:DBSP_WORD_W];
            due = 1'b0;
            rel = 1'b1;
        end
        mem_addr = DBSP_ADDR_W'($urandom);
        rw_select = 1'b1;
        issue_select_n = !((kc + 1) % 2 == 0 && kc >= 3);
        if ((kc + 1) % 2 == 1 && kc >= 2 && cq.size() > 0) begin
            // no beats over a returning read
            if (cq[0].rd || kc + 1 >= last_rd + 4) begin
                wc = cq.pop_front();
                issue_select_n = 1'b0;
                rw_select = wc.rd;
                mem_addr = wc.a;
                if (wc.rd) begin
                    last_rd = kc + 1;
                    rd_edge.push_back(kc + 1);
                end else begin
                    wr_edge = kc + 1;
                end
            end
        end
        if (rel) begin
            #7.5;
            drv = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/dbsp_port_tb.sv */
// Self-checking bench for the burst memory port.
// Assumes the host model owns the link clocks; ref_clk is made here.
`timescale 1ns/100ps
`default_nettype none
module dbsp_port_tb
    import dbsp_pkg::*;
    ;
    localparam int DW2 = 2 * DBSP_WORD_W;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic k_clk;
    logic k_n_clk;
    logic [DBSP_ADDR_W-1:0] mem_addr;
    logic issue_select_n;
    logic rw_select;
    logic [DBSP_WORD_W-1:0] dq_in;
    logic [DBSP_WORD_W-1:0] dq_out;
    logic dq_oe;
    logic read_valid_flag;
    logic echo_timing_out;
    logic echo_timing_out_n;
    logic [DBSP_CNT_W-1:0] commit_count;
    logic write_backlog_full;
    logic write_lost;
    logic clash;
    logic [DW2-1:0] mem [0:(1<<DBSP_ADDR_W)-1];
    logic [DW2-1:0] exp_q[$];
    logic [DBSP_WORD_W-1:0] w0;
    logic [DBSP_ADDR_W-1:0] base;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int edge_exp;

    dbsp_port uut (.ref_clk(ref_clk), .rstn(rstn), .k_clk(k_clk),
        .k_n_clk(k_n_clk), .mem_addr(mem_addr),
        .issue_select_n(issue_select_n), .rw_select(rw_select),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .read_valid_flag(read_valid_flag),
        .echo_timing_out(echo_timing_out),
        .echo_timing_out_n(echo_timing_out_n),
        .commit_count(commit_count),
        .write_backlog_full(write_backlog_full), .write_lost(write_lost));
    dbsp_host_model host (.rstn(rstn), .k_clk(k_clk), .k_n_clk(k_n_clk),
        .mem_addr(mem_addr), .issue_select_n(issue_select_n),
        .rw_select(rw_select), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .clash(clash));

    always #5 ref_clk = ~ref_clk;

    // =====================================================
    // Helpers
    task automatic check(input logic [DW2-1:0] got, input logic [DW2-1:0] e);
        num_checks++;
        if (got !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    // Expected read data noted at issue time, in issue order
    task automatic send(input logic rd, input logic [DBSP_ADDR_W-1:0] a);
        logic [DW2-1:0] w;
        w = DW2'({$urandom, $urandom});
        if (rd) begin
            exp_q.push_back(mem[a]);
        end else begin
            mem[a] = w;
        end
        host.issue(rd, a, w);
    endtask

    // Fixed tail covers the commit crossing into ref_clk
    task automatic wait_idle;
        while (host.cq.size() > 0) begin
            @(posedge k_clk);
        end
        repeat (16) @(posedge k_clk);
    endtask

    task automatic stop_test;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far above the hundred or so ref_clk cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            stop_test;
        end
    end

    // Host must never drive while the port drives
    always @(negedge k_clk) begin
        if (rstn) check(DW2'(clash), DW2'(1'b0));
    end

    // Read watcher: beat0 on echo rise, beat1 on echo fall
    always @(posedge echo_timing_out) begin
        #2;
        check(DW2'(echo_timing_out_n), DW2'(1'b0));
        if (dq_oe === 1'b1 || read_valid_flag === 1'b1) begin
            w0 = dq_out;
            edge_exp = -1;
            if (host.rd_edge.size() > 0) begin
                edge_exp = host.rd_edge.pop_front() + DBSP_RD_LATENCY;
            end
            check(DW2'(host.kc), DW2'(edge_exp));
            check(DW2'(read_valid_flag), DW2'(dq_oe));
            @(negedge echo_timing_out);
            #2;
            if (exp_q.size() > 0) begin
                check({dq_out, w0}, exp_q.pop_front());
            end else begin
                check(DW2'(1'b1), DW2'(1'b0));
            end
        end
    end

    // =====================================================
    // Main sequence
    initial begin
        void'($urandom(99));
        repeat (3) @(posedge ref_clk);
        #1;
        check(DW2'({dq_oe, read_valid_flag, commit_count}), DW2'(1'b0));
        rstn = 1'b1;
        base = DBSP_ADDR_W'($urandom);
        for (int i = 0; i < 6; i++) begin
            send(1'b0, base + DBSP_ADDR_W'(i));
        end
        wait_idle;
        check(DW2'(commit_count), DW2'(6));
        for (int i = 5; i >= 0; i--) begin
            send(1'b1, base + DBSP_ADDR_W'(i));
        end
        send(1'b0, base + 8'h06);
        wait_idle;
        send(1'b1, base + 8'h06);
        wait_idle;
        check(DW2'(commit_count), DW2'(7));
        check(DW2'({write_backlog_full, write_lost}), DW2'(1'b0));
        check(DW2'(exp_q.size()), DW2'(0));
        stop_test;
    end
endmodule
`default_nettype wire
